// File: core/dtc_defs.svh
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ***********************************
// Register word indexes (byte address = 4 * index)
// ***********************************
`define DTC_IDX_T2CTL    6'h18
`define DTC_IDX_T1CTL    6'h19
`define DTC_IDX_HIDATA   6'h1A
`define DTC_IDX_LODATA   6'h1B

// ***********************************
// Control register fields
// ***********************************
`define DTC_RUN          0
`define DTC_PAUSE        1
`define DTC_CS_LO        2
`define DTC_CS_HI        3
`define DTC_OS_LO        4
`define DTC_OS_HI        5
`define DTC_IE           6
`define DTC_IF           7

`define DTC_CS_DIV2      2'h0
`define DTC_CS_DIV32     2'h1
`define DTC_CS_DIV512    2'h2
`define DTC_CS_EXT       2'h3
`define DTC_CS_CASCADE   2'h3

`define DTC_OS_PORT      2'h0
`define DTC_OS_LOW       2'h1
`define DTC_OS_HIGH      2'h2
`define DTC_OS_HOLD      2'h3

// ***********************************
// Reset values and timing
// ***********************************
`define DTC_CTRL_RST     8'h00
`define DTC_DATA_RST     8'h00
`define DTC_CNT_MAX      8'hFF
`define DTC_DIV_W        9
`define DTC_MASK_2       9'h001
`define DTC_MASK_32      9'h01F
`define DTC_MASK_512     9'h1FF

`endif

// File: core/dtc_pkg.sv
package dtc_pkg;
`include "dtc_defs.svh"

    typedef logic [7:0] dtc_byte_t;
    typedef logic [1:0] dtc_sel_t;

    typedef struct packed {
        dtc_byte_t cnt;
        dtc_byte_t latch;
    } dtc_cnt_s;

    typedef struct packed {
        logic [`DTC_DIV_W-1:0] div;
        logic                  ext_prev;
    } dtc_pre_s;

    typedef struct packed {
        dtc_byte_t ctl1;
        dtc_byte_t ctl2;
        dtc_byte_t data1;
        dtc_byte_t data2;
        logic      lvl;
        logic      ack;
        dtc_byte_t rdat;
    } dtc_core_s;

endpackage : dtc_pkg

// File: core/dtc_clk_sel.sv
`timescale 1ns/1ns
`include "dtc_defs.svh"
module dtc_clk_sel (
    input  wire logic            core_clk,   // System clock
    input  wire logic            rst,        // Sync reset
    input  wire logic            inst_tick,  // One pulse per instruction cycle
    input  wire logic            ext_pin,    // External count input
    input  wire dtc_pkg::dtc_sel_t sel1,     // First timer select
    input  wire dtc_pkg::dtc_sel_t sel2,     // Second timer select
    output logic                 tick1,      // First count pulse
    output logic                 tick2       // Second count pulse
);
    import dtc_pkg::*;

    dtc_pre_s st;
    dtc_pre_s next_st;

    // Internal clock pulse for a select code
    function automatic logic int_tick(input dtc_sel_t s, input logic [`DTC_DIV_W-1:0] d,
                                      input logic t);
        logic [`DTC_DIV_W-1:0] m;
        m = (s == `DTC_CS_DIV2) ? `DTC_MASK_2 :
            (s == `DTC_CS_DIV32) ? `DTC_MASK_32 : `DTC_MASK_512;
        return t && ((d & m) == m);
    endfunction : int_tick

    always_comb begin
        next_st          = st;
        next_st.ext_prev = ext_pin;
        if (inst_tick) begin
            next_st.div = st.div + `DTC_DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick1 = (sel1 == `DTC_CS_EXT) ? (ext_pin & ~st.ext_prev)
                                          : int_tick(sel1, st.div, inst_tick);
    assign tick2 = int_tick(sel2, st.div, inst_tick);

endmodule : dtc_clk_sel

// File: core/dtc_counter.sv
`timescale 1ns/1ns
module dtc_counter (
    input  wire logic              core_clk, // System clock
    input  wire logic              rst,      // Sync reset
    input  wire logic              inc,      // Count up
    input  wire logic              clr,      // Clear count
    input  wire logic              load,     // Reload compare latch
    input  wire dtc_pkg::dtc_byte_t data,    // Compare data register
    output dtc_pkg::dtc_byte_t     cnt,      // Current count
    output logic                   eq        // Count equals latch
);
    import dtc_pkg::*;

    dtc_cnt_s st;
    dtc_cnt_s next_st;

    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.cnt = '0;
        end else if (inc) begin
            next_st.cnt = st.cnt + 8'h01;
        end
        if (load) begin
            next_st.latch = data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cnt = st.cnt;
    assign eq  = (st.cnt == st.latch);

endmodule : dtc_counter

// File: core/dtc_top.sv
// Summary of operation
// - First select: 00 is 2, 01 is 32, 10 is 512 cycles, 11 external edges.
// - First run rising clears counter; counts if not paused; run low halts.
// - First pause freezes count; releasing it while running resumes from held value.
// - Output field 00 leaves pin as port bit; nonzero makes it square-wave output.
// - Writing 01 drives square-wave pin low, 10 drives it high.
// - Field 11 with run low holds the preset level.
// - Each first-timer or cascaded match inverts the pin while output enabled.
// - Eight-bit mode: first flag sets when counter equals its latch.
// - Cascaded mode: first flag sets only when both halves match together.
// - First request asserted only while first flag and enable are both set.
// - Writing 0 clears a match flag; writing 1 leaves it unchanged.
// - Second flag sets on its own match; request needs flag and enable.
// - Second select offers same three clocks; 11 selects cascaded mode.
// - Second run and pause behave like the first ones in eight-bit mode.
// - Cascaded counter started and stopped only by first run bit.
// - Cascaded counter paused only by first pause bit.
// - Cascaded mode uses only the first flag; second gives no request.
// - Cascaded mode request gated only by first enable bit.
// - Cascaded start clears low and high counters together.
// - Cascaded mode chains counters: first is low byte, second high byte.
// - Each match clears counter and reloads latch from its data register.
`timescale 1ns/1ns
`include "dtc_defs.svh"
module dtc_top (
    input  wire logic        core_clk,              // System clock, 250 MHz
    input  wire logic        rst,                   // Sync reset, active high
    input  wire logic [7:0]  wb_adr_i,              // Byte address
    input  wire logic [31:0] wb_dat_i,              // Write data
    output logic [31:0]      wb_dat_o,              // Read data
    input  wire logic        wb_we_i,               // Write enable
    input  wire logic [3:0]  wb_sel_i,              // Byte selects
    input  wire logic        wb_cyc_i,              // Cycle
    input  wire logic        wb_stb_i,              // Strobe
    output logic             wb_ack_o,              // Acknowledge
    input  wire logic        inst_tick,             // Instruction cycle pulse
    input  wire logic        external_count_pin,    // External count clock
    input  wire logic        shared_output_port_bit,// Port data for shared pin
    input  wire logic        port_dir_out,          // Port direction, 1 = output
    output logic             square_wave_pin_out,   // Shared pin level
    output logic             square_wave_pin_oe_n,  // Shared pin enable, low drives
    output logic             first_irq,             // First timer request
    output logic             second_irq             // Second timer request
);
    import dtc_pkg::*;

    // ***********************************
    // State
    // ***********************************
    dtc_core_s st;
    dtc_core_s next_st;

    dtc_byte_t cnt [2];
    logic      eq  [2];
    logic      inc [2];
    logic      clr [2];
    logic      load[2];
    dtc_byte_t dat [2];

    logic      tick1;
    logic      tick2;
    logic      mode16;
    logic      req;
    logic      wr;
    logic      wr_ctl1;
    logic      wr_ctl2;
    logic      start1;
    logic      start2;
    logic      run1;
    logic      run2;
    logic      cnt1_ev;
    logic      cnt2_ev;
    logic      match1;
    logic      match2;
    logic      match16;
    logic      set1;
    logic      set2;
    logic      wave_on;
    dtc_byte_t wbyte;
    logic [5:0] idx;

    // Register index hit
    function automatic logic hit(input logic [5:0] a, input logic [5:0] k);
        return a == k;
    endfunction : hit

    // ***********************************
    // Bus decode
    // ***********************************
    assign idx     = wb_adr_i[7:2];
    assign wbyte   = wb_dat_i[7:0];
    assign req     = wb_cyc_i & wb_stb_i;
    assign wr      = req & wb_we_i & st.ack & wb_sel_i[0];
    assign wr_ctl1 = wr & hit(idx, `DTC_IDX_T1CTL);
    assign wr_ctl2 = wr & hit(idx, `DTC_IDX_T2CTL);

    // ***********************************
    // Mode and run control
    // ***********************************
    // cascade select
    assign mode16 = (st.ctl2[`DTC_CS_HI:`DTC_CS_LO] == `DTC_CS_CASCADE);

    assign start1 = wr_ctl1 & wbyte[`DTC_RUN] & ~st.ctl1[`DTC_RUN];
    assign start2 = wr_ctl2 & wbyte[`DTC_RUN] & ~st.ctl2[`DTC_RUN] & ~mode16;

    assign run1 = st.ctl1[`DTC_RUN] & ~st.ctl1[`DTC_PAUSE];
    assign run2 = st.ctl2[`DTC_RUN] & ~st.ctl2[`DTC_PAUSE] & ~mode16;

    assign cnt1_ev = run1 & tick1;
    assign cnt2_ev = run2 & tick2;

    assign match1  = cnt1_ev & eq[0] & ~mode16;
    assign match2  = cnt2_ev & eq[1];
    assign match16 = cnt1_ev & eq[0] & eq[1] & mode16;

    assign set1 = match1 | match16;
    assign set2 = match2 & ~mode16;

    // ***********************************
    // Counter circuits
    // ***********************************
    always_comb begin
        clr[0]  = start1 | match1 | match16;
        load[0] = clr[0];
        inc[0]  = cnt1_ev;
        dat[0]  = st.data1;
        if (mode16) begin
            // high byte counts on low carry
            clr[1] = start1 | match16;
            inc[1] = cnt1_ev & (cnt[0] == `DTC_CNT_MAX);
        end else begin
            clr[1] = start2 | match2;
            inc[1] = cnt2_ev;
        end
        load[1] = clr[1];
        dat[1]  = st.data2;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cnt
            dtc_counter u_cnt (
                .core_clk (core_clk),
                .rst      (rst),
                .inc      (inc[gi]),
                .clr      (clr[gi]),
                .load     (load[gi]),
                .data     (dat[gi]),
                .cnt      (cnt[gi]),
                .eq       (eq[gi])
            );
        end
    endgenerate

    dtc_clk_sel u_sel (
        .core_clk (core_clk),
        .rst      (rst),
        .inst_tick(inst_tick),
        .ext_pin  (external_count_pin),
        .sel1     (st.ctl1[`DTC_CS_HI:`DTC_CS_LO]),
        .sel2     (st.ctl2[`DTC_CS_HI:`DTC_CS_LO]),
        .tick1    (tick1),
        .tick2    (tick2)
    );

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        next_st     = st;
        next_st.ack = req & ~st.ack;
        if (req & ~st.ack) begin
            next_st.rdat = '0;
            if (hit(idx, `DTC_IDX_T1CTL)) begin
                next_st.rdat = st.ctl1;
            end
            if (hit(idx, `DTC_IDX_T2CTL)) begin
                next_st.rdat = st.ctl2;
            end
            if (hit(idx, `DTC_IDX_LODATA)) begin
                next_st.rdat = cnt[0];
            end
            if (hit(idx, `DTC_IDX_HIDATA)) begin
                next_st.rdat = cnt[1];
            end
        end
        if (wr_ctl1) begin
            next_st.ctl1[6:0] = wbyte[6:0];
            if (wbyte[`DTC_OS_HI:`DTC_OS_LO] == `DTC_OS_LOW) begin
                next_st.lvl = 1'b0;
            end
            if (wbyte[`DTC_OS_HI:`DTC_OS_LO] == `DTC_OS_HIGH) begin
                next_st.lvl = 1'b1;
            end
        end
        if (wr_ctl2) begin
            next_st.ctl2[6:0] = wbyte[6:0];
        end
        if (wr & hit(idx, `DTC_IDX_LODATA)) begin
            next_st.data1 = wbyte;
        end
        if (wr & hit(idx, `DTC_IDX_HIDATA)) begin
            next_st.data2 = wbyte;
        end
        next_st.ctl1[`DTC_IF] = (st.ctl1[`DTC_IF] & ~(wr_ctl1 & ~wbyte[`DTC_IF])) | set1;
        next_st.ctl2[`DTC_IF] = (st.ctl2[`DTC_IF] & ~(wr_ctl2 & ~wbyte[`DTC_IF])) | set2;
        if (set1 & wave_on) begin
            next_st.lvl = ~st.lvl;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st.ctl1  <= `DTC_CTRL_RST;
            st.ctl2  <= `DTC_CTRL_RST;
            st.data1 <= `DTC_DATA_RST;
            st.data2 <= `DTC_DATA_RST;
            st.lvl   <= 1'b0;
            st.ack   <= 1'b0;
            st.rdat  <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign wb_ack_o = st.ack;
    assign wb_dat_o = {24'h000000, st.rdat};

    assign wave_on              = (st.ctl1[`DTC_OS_HI:`DTC_OS_LO] != `DTC_OS_PORT);
    assign square_wave_pin_out  = wave_on ? st.lvl : shared_output_port_bit;
    assign square_wave_pin_oe_n = wave_on ? 1'b0 : ~port_dir_out;

    assign first_irq  = st.ctl1[`DTC_IF] & st.ctl1[`DTC_IE];
    assign second_irq = st.ctl2[`DTC_IF] & st.ctl2[`DTC_IE] & ~mode16;

    // ***********************************
    // Checks
    // ***********************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    start_clear_a: assert property (
        start1 & ~mode16 |=> cnt[0] == 8'h00)
        else $error("first counter not cleared at start");

    pause_hold_a: assert property (
        ~mode16 & st.ctl1[`DTC_RUN] & st.ctl1[`DTC_PAUSE] & ~wr_ctl1 |=> $stable(cnt[0]))
        else $error("paused counter moved");

    pin_port_a: assert property (
        ~wave_on |-> square_wave_pin_out == shared_output_port_bit
                     && square_wave_pin_oe_n == ~port_dir_out)
        else $error("port bit not passed through");

    preset_lvl_a: assert property (
        wr_ctl1 & ~set1 & (wbyte[`DTC_OS_HI:`DTC_OS_LO] == `DTC_OS_HIGH)
        |=> square_wave_pin_out && !square_wave_pin_oe_n)
        else $error("preset high not driven");

    hold_lvl_a: assert property (
        ~st.ctl1[`DTC_RUN] & ~wr_ctl1 & wave_on |=> square_wave_pin_out == $past(st.lvl))
        else $error("stopped level changed");

    toggle_pin_a: assert property (
        set1 & wave_on & ~wr_ctl1 |=> st.lvl != $past(st.lvl))
        else $error("match did not invert pin");

    flag_set_a: assert property (
        cnt1_ev & eq[0] & ~mode16 |=> st.ctl1[`DTC_IF] && first_irq == st.ctl1[`DTC_IE])
        else $error("first flag not set on match");

    flag16_a: assert property (
        mode16 & cnt1_ev & eq[0] & ~eq[1] & ~st.ctl1[`DTC_IF] & ~wr_ctl1 & (cnt[0] != 8'hFF)
        |=> !st.ctl1[`DTC_IF] && cnt[1] == $past(cnt[1]))
        else $error("cascade flag set on half match");

    flag_clear_a: assert property (
        wr_ctl1 & ~wbyte[`DTC_IF] & ~set1 |=> !st.ctl1[`DTC_IF] && !first_irq)
        else $error("zero write did not clear flag");

    second_quiet_a: assert property (
        mode16 |-> !second_irq)
        else $error("second request in cascade mode");

    clear_both_a: assert property (
        start1 & mode16 |=> cnt[0] == 8'h00 && cnt[1] == 8'h00)
        else $error("cascade start left a half uncleared");

    first_irq_a: assert property (
        set1 & st.ctl1[`DTC_IE] & ~wr_ctl1 |=> first_irq)
        else $error("first request missing after match");

    second_flag_a: assert property (
        match2 & st.ctl2[`DTC_IE] & ~wr_ctl2 |=> st.ctl2[`DTC_IF] && second_irq)
        else $error("second flag or request missing after match");

    second_start_a: assert property (
        start2 |=> cnt[1] == 8'h00)
        else $error("second counter not cleared at start");

    casc_stop_a: assert property (
        mode16 & ~st.ctl1[`DTC_RUN] & ~wr_ctl1 |=> $stable(cnt[1]))
        else $error("cascade high half moved while stopped");

    casc_count_a: assert property (
        mode16 & cnt1_ev & ~eq[0] & ~wr_ctl1 |=> cnt[0] == $past(cnt[0]) + 8'h01)
        else $error("cascade low half did not count");

    casc_irq_a: assert property (
        set1 & mode16 & st.ctl1[`DTC_IE] & ~wr_ctl1 |=> first_irq)
        else $error("cascade request not gated by first enable");

    carry_chain_a: assert property (
        mode16 & cnt1_ev & (cnt[0] == 8'hFF) & ~eq[0] & ~wr_ctl1
        |=> cnt[1] == $past(cnt[1]) + 8'h01)
        else $error("high half missed low carry");

    reload_clear_a: assert property (
        set1 |=> cnt[0] == 8'h00)
        else $error("match did not clear first counter");

endmodule : dtc_top

// File: verif/dtc_ext_src.sv
`timescale 1ns/1ns
module dtc_ext_src (
    input  wire logic       core_clk, // System clock
    input  wire logic       rst,      // Sync reset
    input  wire logic       go,       // Start a burst
    input  wire logic [7:0] n,        // Edges in burst
    input  wire logic       pin_out,  // Device pin level
    input  wire logic       pin_oe_n, // Device pin enable, low drives
    output logic            ext_pin,  // Count clock to device
    output logic            busy,     // Burst in progress
    output logic            pin_lvl   // Level seen at the load
);
    typedef struct packed {
        logic [7:0] left;
        logic [2:0] ph;
        logic       ext;
    } dtc_src_s;

    dtc_src_s st;
    dtc_src_s next_st;

    // ***********************************
    // Count clock bursts, low between them
    // ***********************************
    // pin fed as input
    always_comb begin
        next_st = st;
        if (go) begin
            next_st.left = n;
            next_st.ph = 3'h0;
        end else if (st.left != 8'h00) begin
            next_st.ph = st.ph + 3'h1;
            if (st.ph == 3'h7) begin
                next_st.left = st.left - 8'h01;
            end
        end
        next_st.ext = (st.left != 8'h00) && st.ph[2];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= 12'h000;
        end else begin
            st <= next_st;
        end
    end

    assign ext_pin = st.ext;
    assign busy    = (st.left != 8'h00);
    // Pull-up holds a released pin high
    assign pin_lvl = pin_oe_n ? 1'b1 : pin_out;
endmodule : dtc_ext_src

// File: verif/dtc_tb_top.sv
`timescale 1ns/1ns
module dtc_tb_top;
    import dtc_pkg::*;
    localparam logic [7:0] A_T2 = 8'h60;
    localparam logic [7:0] A_T1 = 8'h64;
    localparam logic [7:0] A_HI = 8'h68;
    localparam logic [7:0] A_LO = 8'h6C;
    localparam int         LIMIT = 20000;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic [7:0]  adr      = 8'h00;
    logic [31:0] wdat     = 32'h0;
    logic [31:0] rdat;
    logic        we       = 1'b0;
    logic [3:0]  sel      = 4'hF;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        ack;
    logic        port_bit = 1'b0;
    logic        port_dir = 1'b0;
    logic        ext_go   = 1'b0;
    logic [7:0]  ext_n    = 8'h00;
    logic        pin_out, pin_oe_n, irq1, irq2, ext_pin, ext_busy, pin_lvl;
    logic [7:0]  q;
    logic [7:0]  c1;
    int          t;
    int          fails    = 0;
    int          n_tests  = 0;
    int          cycles   = 0;

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    dtc_top i_dut (.core_clk(core_clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .inst_tick(1'b1), .external_count_pin(ext_pin),
        .shared_output_port_bit(port_bit), .port_dir_out(port_dir),
        .square_wave_pin_out(pin_out), .square_wave_pin_oe_n(pin_oe_n),
        .first_irq(irq1), .second_irq(irq2));

    dtc_ext_src i_src (.core_clk(core_clk), .rst(rst), .go(ext_go), .n(ext_n),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_pin(ext_pin), .busy(ext_busy),
        .pin_lvl(pin_lvl));

    // ***********************************
    // Shared tasks
    // ***********************************
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                        input logic [3:0] s);
        @(posedge core_clk);
        adr <= a;
        we <= w;
        wdat <= {24'h000000, d};
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge core_clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 8'h00, 4'hF);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic wait_irq(input logic two, input int n, output int k);
        k = 0;
        while (k < n && (two ? irq2 : irq1) !== 1'b1) begin
            @(posedge core_clk);
            k++;
        end
    endtask : wait_irq

    // ***********************************
    // Scenarios
    // ***********************************
    task automatic t_reset;
        logic [7:0] al[5] = '{A_T2, A_T1, A_HI, A_LO, 8'h70};
        for (int i = 0; i < 5; i++) begin
            rd(al[i]);
            check(q, 8'h00);
        end
        check({irq1, irq2, pin_oe_n}, 3'h1);
        xfer(A_T1, 1'b1, 8'h40, 4'hE);
        rd(A_T1);
        check(q, 8'h00);
    endtask : t_reset

    task automatic t_timer1;
        wr(A_T2, 8'h00);
        wr(A_LO, 8'h03);
        wr(A_T1, 8'h41);
        wait_irq(1'b0, 40, t);
        check(t >= 5 && t <= 12, 1'b1);
        rd(A_T1);
        check(q[7], 1'b1);
        wr(A_T1, 8'h80);
        idle(1);
        check(irq1, 1'b0);
        rd(A_T1);
        check(q, 8'h80);
        wr(A_T1, 8'h00);
        rd(A_T1);
        check(q, 8'h00);
    endtask : t_timer1

    task automatic t_pause;
        wr(A_LO, 8'hFF);
        wr(A_T1, 8'h03);
        rd(A_LO);
        check(q, 8'h00);
        wr(A_T1, 8'h01);
        idle(40);
        wr(A_T1, 8'h03);
        rd(A_LO);
        c1 = q;
        check(c1 != 8'h00, 1'b1);
        idle(40);
        rd(A_LO);
        check(q, c1);
        wr(A_T1, 8'h01);
        idle(20);
        wr(A_T1, 8'h00);
        rd(A_LO);
        check(q > c1, 1'b1);
        c1 = q;
        idle(40);
        rd(A_LO);
        check(q, c1);
        wr(A_T1, 8'h03);
        rd(A_LO);
        check(q, 8'h00);
        wr(A_T1, 8'h00);
    endtask : t_pause

    task automatic t_divs;
        logic [7:0] a;
        logic [7:0] ad;
        int         w[3] = '{254, 1022, 1022};
        int         e[3] = '{128, 32, 2};
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 3; s++) begin
                a = (m == 1) ? A_T2 : A_T1;
                ad = (m == 1) ? A_HI : A_LO;
                wr(ad, 8'hFF);
                wr(a, {4'h0, s[1:0], 2'b11});
                wr(a, {4'h0, s[1:0], 2'b01});
                idle(w[s]);
                wr(a, {4'h0, s[1:0], 2'b11});
                rd(ad);
                check(q >= e[s] - 1 && q <= e[s] + 1, 1'b1);
                wr(a, 8'h00);
            end
        end
        wr(A_T1, 8'h0F);
        wr(A_T1, 8'h0D);
        @(posedge core_clk);
        ext_n <= 8'h05;
        ext_go <= 1'b1;
        @(posedge core_clk);
        ext_go <= 1'b0;
        idle(2);
        while (ext_busy === 1'b1) @(posedge core_clk);
        idle(6);
        rd(A_LO);
        check(q, 8'h05);
        wr(A_T1, 8'h00);
    endtask : t_divs

    task automatic t_wave;
        port_dir <= 1'b1;
        port_bit <= 1'b1;
        idle(2);
        check({pin_oe_n, pin_out}, 2'h1);
        port_dir <= 1'b0;
        wr(A_T1, 8'h10);
        idle(1);
        check({pin_oe_n, pin_lvl}, 2'h0);
        wr(A_T1, 8'h20);
        idle(1);
        check({pin_oe_n, pin_out}, 2'h1);
        wr(A_T1, 8'h30);
        idle(20);
        check({pin_oe_n, pin_out}, 2'h1);
        wr(A_LO, 8'h20);
        wr(A_T1, 8'h71);
        wait_irq(1'b0, 100, t);
        idle(1);
        check({t < 100, pin_lvl}, 2'h2);
        wr(A_T1, 8'h71);
        idle(1);
        wait_irq(1'b0, 100, t);
        idle(1);
        check({t < 100, pin_lvl}, 2'h3);
        wr(A_T1, 8'h00);
        idle(1);
        check(pin_oe_n, 1'b1);
    endtask : t_wave

    task automatic t_timer2;
        wr(A_HI, 8'h02);
        wr(A_T2, 8'h41);
        wait_irq(1'b1, 40, t);
        check({t >= 4 && t <= 10, irq1}, 2'h2);
        wr(A_T2, 8'h01);
        idle(1);
        check(irq2, 1'b0);
        wr(A_T2, 8'h00);
    endtask : t_timer2

    task automatic t_casc;
        wr(A_LO, 8'h04);
        wr(A_HI, 8'h02);
        wr(A_T2, 8'h4E);
        wr(A_T1, 8'h41);
        wait_irq(1'b0, 1200, t);
        check(t >= 1024 && t <= 1044, 1'b1);
        check(irq2, 1'b0);
        rd(A_T2);
        check(q[7], 1'b0);
        idle(600);
        wr(A_T1, 8'h43);
        rd(A_HI);
        check(q, 8'h01);
        wr(A_T1, 8'h00);
        wr(A_T1, 8'h03);
        rd(A_HI);
        check(q, 8'h00);
        rd(A_LO);
        check(q, 8'h00);
        wr(A_T1, 8'h00);
        wr(A_T2, 8'h00);
    endtask : t_casc

    // ***********************************
    // Main sequence and timeout
    // ***********************************
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_timer1;
        t_pause;
        t_divs;
        t_wave;
        t_timer2;
        t_casc;
        complete_run;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            complete_run;
        end
    end
endmodule : dtc_tb_top
